//--- verilog/isf_cfg.svh
// Offsets, field positions, reset values and sizing constants of the sensor FIFO
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH
`define ISF_ADDR_CONFIG      8'h13
`define ISF_ADDR_READ_PORT   8'h14
`define ISF_ADDR_LEVEL_FLAGS 8'h15
`define ISF_CONFIG_RESET     8'h00
`define ISF_READ_IDLE_DATA   8'h00
`define ISF_RD_ENABLE_BIT    7
`define ISF_WTM_MSB          5
`define ISF_WTM_LSB          4
`define ISF_SIZE_MSB         3
`define ISF_SIZE_LSB         2
`define ISF_MODE_MSB         1
`define ISF_MODE_LSB         0
`define ISF_CMD_FIFO_ACCESS  8'h0D
`define ISF_BUF_BYTES        1536
`define ISF_SENSOR_BYTES     6
`define ISF_BASE_SAMPLES     16
`define ISF_FSS_STEPS        8
`define ISF_FSS_MAX          15
`endif

//--- verilog/isf_pkg.sv
// Types shared by the sensor FIFO
package isf_pkg;
    typedef enum logic [1:0] {
        ISF_MODE_BYPASS = 2'h0,
        ISF_MODE_STOP   = 2'h1,
        ISF_MODE_STREAM = 2'h2,
        ISF_MODE_UNUSED = 2'h3
    } isf_mode_e;
    typedef enum logic [1:0] {
        ISF_WR_IDLE = 2'b01,
        ISF_WR_BUSY = 2'b10
    } isf_wr_state_e;
endpackage

//--- verilog/isf_byte_mem.sv
// Byte-wide sample memory, synchronous write, asynchronous read
`timescale 1ns/1ps
module isf_byte_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 1536,
    parameter int AW    = 11
) (
    // Clock
    input  wire logic             clock,
    // Write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule

//--- verilog/isf_sensor_fifo.sv
// Sensor sample FIFO with register port, modes, watermark and level status
//
// Notes on behaviour
// - 1536-byte FIFO for accel, gyro, mag samples
// - Consecutive data reads form one burst
// - Reading the data register consumes data
// - Mode field: bypass, stop-when-full, streaming
// - Storing starts only with accel or gyro on
// - Watermark reached drives second interrupt pin
// - Read-enable bit 7 gates data reads
// - Frame: accel then gyro, low byte first
// - Third sensor adds six magnetometer bytes
// - Bypass keeps FIFO empty, outputs overwritten
// - Stop-when-full halts until emptied
// - Streaming discards oldest frame when full
// - Watermark at quarter, half, three quarters
// - Size field: 16..128 samples per sensor, 64 at most with three sensors
// - Status: watermark, overflow, not-empty, level
// - Level field is coarse, scaled to size
`timescale 1ns/1ps
`include "isf_cfg.svh"
module isf_sensor_fifo #(
    parameter int BUF_BYTES = `ISF_BUF_BYTES
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Command register decode
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    // Sensor side
    input  wire logic        accel_en,
    input  wire logic        gyro_en,
    input  wire logic        mag_en,
    input  wire logic        sample_valid,
    input  wire logic [47:0] accel_data,
    input  wire logic [47:0] gyro_data,
    input  wire logic [47:0] mag_data,
    // Bypass output data registers and interrupt
    output logic      [47:0] out_accel,
    output logic      [47:0] out_gyro,
    output logic      [47:0] out_mag,
    output logic             second_interrupt_pin
);
    import isf_pkg::*;

    localparam int AW = 11;
    localparam int CW = 12;

    function automatic logic [1:0] count_sensors(input logic a, input logic g, input logic m);
        count_sensors = 2'({1'b0, a} + {1'b0, g} + {1'b0, m});
    endfunction

    function automatic logic [CW-1:0] cap_bytes(input logic [1:0] size, input logic [1:0] n);
        logic [1:0] s;
        s = size;
        // 128 per sensor would exceed the memory with three sensors
        if (n == 2'd3 && s == 2'd3) begin
            s = 2'd2;
        end
        cap_bytes = CW'((`ISF_BASE_SAMPLES << s) * `ISF_SENSOR_BYTES * int'(n));
    endfunction

    function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p, input int n);
        int s;
        s = int'(p) + n;
        if (s >= BUF_BYTES) begin
            s = s - BUF_BYTES;
        end
        ptr_add = AW'(s);
    endfunction

    function automatic logic [143:0] pack_frame(input logic ae, input logic ge, input logic me);
        int k;
        pack_frame = '0;
        k = 0;
        if (ae) begin
            pack_frame[k*48 +: 48] = accel_data;
            k = k + 1;
        end
        if (ge) begin
            pack_frame[k*48 +: 48] = gyro_data;
            k = k + 1;
        end
        if (me) begin
            pack_frame[k*48 +: 48] = mag_data;
        end
    endfunction

    logic [7:0]     cfg_ff;
    logic [1:0]     nsens_ff;
    logic           access_ff;
    logic [CW-1:0]  count_ff;
    logic [AW-1:0]  wr_ptr_ff;
    logic [AW-1:0]  rd_ptr_ff;
    logic [4:0]     head_off_ff;
    logic [4:0]     bytes_left_ff;
    logic [143:0]   frame_sr_ff;
    logic           full_lock_ff;
    logic           ovf_ff;
    logic           wtm_hit_ff;
    isf_wr_state_e  wr_state_ff;

    isf_mode_e      mode;
    logic [1:0]     wtm_sel;
    logic [1:0]     nsens;
    logic [4:0]     frame_bytes;
    logic [CW-1:0]  cap;
    logic [CW-1:0]  thr;
    logic [CW-1:0]  nxt_count;
    logic [4:0]     nxt_head_off;
    logic [4:0]     drop_bytes;
    logic [7:0]     mem_rd_data;
    logic [3:0]     fss;
    logic           cfg_write;
    logic           flush;
    logic           rd_allowed;
    logic           pop;
    logic           wr_b;
    logic           take;
    logic           fits;
    logic           accept;
    logic           lost;
    logic           drop;

    assign mode        = isf_mode_e'(cfg_ff[`ISF_MODE_MSB:`ISF_MODE_LSB]);
    assign wtm_sel     = cfg_ff[`ISF_WTM_MSB:`ISF_WTM_LSB];
    assign nsens       = count_sensors(accel_en, gyro_en, mag_en);
    assign frame_bytes = 5'(`ISF_SENSOR_BYTES * int'(nsens_ff));
    assign cap         = cap_bytes(cfg_ff[`ISF_SIZE_MSB:`ISF_SIZE_LSB], nsens_ff);
    assign thr         = CW'((int'(cap) * int'(wtm_sel)) / 4);
    assign cfg_write   = reg_wr && reg_addr == `ISF_ADDR_CONFIG;
    // Layout or capacity changes invalidate stored frames
    assign flush = (cfg_write && reg_wdata[3:0] != cfg_ff[3:0]) || nsens != nsens_ff;
    assign rd_allowed = cfg_ff[`ISF_RD_ENABLE_BIT] && access_ff;
    assign pop        = reg_rd && reg_addr == `ISF_ADDR_READ_PORT && rd_allowed && count_ff != '0;
    assign wr_b       = wr_state_ff == ISF_WR_BUSY;
    // Unused mode code stores nothing, like bypass
    assign take = sample_valid && (accel_en || gyro_en) && wr_state_ff == ISF_WR_IDLE && !flush
                  && (mode == ISF_MODE_STOP || mode == ISF_MODE_STREAM);
    assign fits   = 13'(count_ff) + 13'(frame_bytes) <= 13'(cap);
    assign accept = take && (mode == ISF_MODE_STREAM || (fits && !full_lock_ff));
    assign lost   = take && mode == ISF_MODE_STOP && (!fits || full_lock_ff);
    assign drop   = take && mode == ISF_MODE_STREAM && !fits;

    always_comb begin
        nxt_head_off = head_off_ff;
        if (pop) begin
            nxt_head_off = (head_off_ff + 5'd1 == frame_bytes) ? 5'd0 : head_off_ff + 5'd1;
        end
        // Remainder of the oldest frame keeps frames aligned for the host
        drop_bytes = drop ? frame_bytes - nxt_head_off : 5'd0;
        nxt_count  = CW'(int'(count_ff) + int'(wr_b) - int'(pop) - int'(drop_bytes));
        if (flush) begin
            nxt_count = '0;
        end
    end

    always_comb begin
        int lvl;
        lvl = 0;
        if (cap != '0) begin
            lvl = (int'(count_ff) * `ISF_FSS_STEPS) / int'(cap);
        end
        fss = (lvl > `ISF_FSS_MAX) ? 4'hF : 4'(lvl);
    end

    isf_byte_mem #(
        .WIDTH (8),
        .DEPTH (BUF_BYTES),
        .AW    (AW)
    ) u_mem (
        .clock   (clock),
        .wr_en   (wr_b),
        .wr_addr (wr_ptr_ff),
        .wr_data (frame_sr_ff[7:0]),
        .rd_addr (rd_ptr_ff),
        .rd_data (mem_rd_data)
    );

    // Configuration and read access grant
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_ff    <= `ISF_CONFIG_RESET;
            access_ff <= 1'b0;
            nsens_ff  <= 2'd0;
        end else begin
            nsens_ff <= nsens;
            if (cfg_write) begin
                cfg_ff <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            end
            if (cmd_valid && cmd_code == `ISF_CMD_FIFO_ACCESS) begin
                access_ff <= 1'b1;
            end else if (cfg_write && !reg_wdata[`ISF_RD_ENABLE_BIT]) begin
                access_ff <= 1'b0;
            end
        end
    end

    // Frame writer, one byte per clock
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_state_ff   <= ISF_WR_IDLE;
            bytes_left_ff <= 5'd0;
            frame_sr_ff   <= '0;
            wr_ptr_ff     <= '0;
        end else if (flush) begin
            wr_state_ff   <= ISF_WR_IDLE;
            bytes_left_ff <= 5'd0;
            wr_ptr_ff     <= '0;
        end else begin
            unique case (wr_state_ff)
                ISF_WR_IDLE: begin
                    if (accept) begin
                        frame_sr_ff   <= pack_frame(accel_en, gyro_en, mag_en);
                        bytes_left_ff <= frame_bytes;
                        wr_state_ff   <= ISF_WR_BUSY;
                    end
                end
                ISF_WR_BUSY: begin
                    frame_sr_ff   <= {8'h00, frame_sr_ff[143:8]};
                    wr_ptr_ff     <= ptr_add(wr_ptr_ff, 1);
                    bytes_left_ff <= bytes_left_ff - 5'd1;
                    if (bytes_left_ff == 5'd1) begin
                        wr_state_ff <= ISF_WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Read pointer, fill count and frame-head offset
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_ptr_ff   <= '0;
            count_ff    <= '0;
            head_off_ff <= 5'd0;
        end else begin
            count_ff <= nxt_count;
            if (flush) begin
                rd_ptr_ff   <= '0;
                head_off_ff <= 5'd0;
            end else begin
                rd_ptr_ff   <= ptr_add(rd_ptr_ff, int'(pop) + int'(drop_bytes));
                head_off_ff <= drop ? 5'd0 : nxt_head_off;
            end
        end
    end

    // Status flags
    always_ff @(posedge clock) begin
        if (rst) begin
            full_lock_ff <= 1'b0;
            ovf_ff       <= 1'b0;
            wtm_hit_ff   <= 1'b0;
        end else begin
            if (flush || nxt_count == '0) begin
                full_lock_ff <= 1'b0;
            end else if (lost) begin
                full_lock_ff <= 1'b1;
            end
            // Set wins over the clear by status read
            if (lost || drop) begin
                ovf_ff <= 1'b1;
            end else if (reg_rd && reg_addr == `ISF_ADDR_LEVEL_FLAGS) begin
                ovf_ff <= 1'b0;
            end
            wtm_hit_ff <= wtm_sel != 2'd0 && nxt_count != '0 && nxt_count >= thr && !flush;
        end
    end

    assign second_interrupt_pin = wtm_hit_ff;

    // Register read data
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ISF_ADDR_CONFIG:      reg_rdata <= cfg_ff;
                `ISF_ADDR_READ_PORT:   reg_rdata <= pop ? mem_rd_data : `ISF_READ_IDLE_DATA;
                `ISF_ADDR_LEVEL_FLAGS: reg_rdata <= {1'b0, wtm_hit_ff, ovf_ff, count_ff != '0, fss};
                default:               reg_rdata <= 8'h00;
            endcase
        end
    end

    // Bypass output data registers
    always_ff @(posedge clock) begin
        if (rst) begin
            out_accel <= '0;
            out_gyro  <= '0;
            out_mag   <= '0;
        end else if (sample_valid && (mode == ISF_MODE_BYPASS || mode == ISF_MODE_UNUSED)) begin
            out_accel <= accel_data;
            out_gyro  <= gyro_data;
            out_mag   <= mag_data;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_frame_taken;
        accept;
    endsequence

    sequence s_six_bytes;
        wr_b [*6];
    endsequence

    a_bypass_stays_empty: assert property (mode == ISF_MODE_BYPASS && count_ff == '0 && !flush |=> count_ff == '0)
        else $error("bypass mode stored data");
    a_read_gate_blocks: assert property (reg_rd && reg_addr == `ISF_ADDR_READ_PORT && !cfg_ff[`ISF_RD_ENABLE_BIT]
        |=> reg_rdata == 8'h00 && (count_ff >= $past(count_ff) || $past(flush || drop)))
        else $error("data read not blocked");
    a_pop_consumes: assert property (pop && !wr_b && !drop && !flush |=> count_ff == $past(count_ff) - 12'h001)
        else $error("read did not consume a byte");
    a_frame_writes: assert property (s_frame_taken |=> s_six_bytes)
        else $error("frame not written byte by byte");
    a_stop_when_full: assert property (mode == ISF_MODE_STOP && full_lock_ff && !flush |=> count_ff <= $past(count_ff))
        else $error("stored while full lock held");
    a_stream_overflow: assert property (drop |=> ovf_ff && head_off_ff == 5'd0)
        else $error("discard did not flag overflow");
    a_store_needs_sensor: assert property ($rose(wr_b) |-> $past(accel_en || gyro_en))
        else $error("stored with no accel or gyro");
    a_capacity_bound: assert property (!$past(flush) |-> count_ff <= cap)
        else $error("fill exceeds capacity");
    a_wtm_follows_fill: assert property (wtm_sel != 2'd0 && count_ff != '0 && count_ff >= thr && !$past(flush)
        && $stable(count_ff) && $stable(cfg_ff) && $stable(nsens_ff) |-> second_interrupt_pin)
        else $error("watermark pin not raised");
endmodule

//--- verification/isf_host_model.sv
// Host-side model driving the register and command ports of the sensor FIFO
`timescale 1ns/1ps
module isf_host_model (
    // Clock
    input  wire logic       clock,
    // Register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    // Command register
    output logic            cmd_valid,
    output logic      [7:0] cmd_code
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
    end

    // Strobe dropped a cycle before the next call so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask

    // Access grant is sent before the read-enable bit is set
    task automatic cmd(input logic [7:0] c);
        @(negedge clock);
        cmd_code  = c;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_code  = ~c;
    endtask
endmodule

//--- verification/inertial_sensor_fifo_tb_top.sv
// Self-checking testbench of the sensor FIFO
`timescale 1ns/1ps
`include "isf_cfg.svh"
module inertial_sensor_fifo_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, cmd_code, v;
    logic        reg_wr, reg_rd, cmd_valid, second_interrupt_pin;
    logic        accel_en = 1'b0, gyro_en = 1'b0, mag_en = 1'b0, sample_valid = 1'b0;
    logic [47:0] accel_data = '0, gyro_data = '0, mag_data = '0;
    logic [47:0] out_accel, out_gyro, out_mag;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #5 clock = ~clock;

    isf_sensor_fifo dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .accel_en(accel_en), .gyro_en(gyro_en), .mag_en(mag_en),
        .sample_valid(sample_valid), .accel_data(accel_data), .gyro_data(gyro_data),
        .mag_data(mag_data), .out_accel(out_accel), .out_gyro(out_gyro), .out_mag(out_mag),
        .second_interrupt_pin(second_interrupt_pin));

    isf_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

    task automatic final_report;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Distinct byte per frame position, and per sample for samples 0 to 12
    function automatic logic [7:0] sb(input int k, input int i);
        return 8'(k * 19 + i + 1);
    endfunction

    // One sample for all sensors at once; spacing covers the 18-cycle frame write
    task automatic send(input int k);
        @(negedge clock);
        for (int i = 0; i < 6; i++) begin
            accel_data[8*i+:8] = sb(k, i);
            gyro_data[8*i+:8]  = sb(k, i + 6);
            mag_data[8*i+:8]   = sb(k, i + 12);
        end
        sample_valid = 1'b1;
        @(negedge clock);
        sample_valid = 1'b0;
        repeat (20) @(negedge clock);
    endtask

    // Whole frame of n bytes (18 unless given) read before the next sample arrives
    task automatic read_frame(input int k, input int n = 18);
        for (int i = 0; i < n; i++) begin
            host.rd(`ISF_ADDR_READ_PORT, v);
            chk(v, sb(k, i));
        end
    endtask

    task automatic status_is(input logic [7:0] exp);
        host.rd(`ISF_ADDR_LEVEL_FLAGS, v);
        chk(v, exp);
    endtask

    initial begin
        #300000;
        n_mismatch++;
        final_report;
    end

    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        host.rd(`ISF_ADDR_CONFIG, v);
        chk(v, `ISF_CONFIG_RESET);
        status_is(8'h00);
        host.rd(`ISF_ADDR_READ_PORT, v);
        chk(v, `ISF_READ_IDLE_DATA);
        host.rd(8'h20, v);
        chk(v, 8'h00);
        // No sensor enabled: nothing stored
        host.wr(`ISF_ADDR_CONFIG, 8'h11);
        send(0);
        status_is(8'h10 & 8'h00);
        accel_en = 1'b1;
        gyro_en  = 1'b1;
        mag_en   = 1'b1;
        send(0);
        status_is(8'h10);
        host.rd(`ISF_ADDR_READ_PORT, v);
        chk(v, 8'h00);
        host.cmd(`ISF_CMD_FIFO_ACCESS);
        host.wr(`ISF_ADDR_CONFIG, 8'h91);
        read_frame(0);
        status_is(8'h00);
        // Quarter of 288 bytes is four frames
        for (int k = 1; k < 4; k++) send(k);
        chk(second_interrupt_pin, 1'b0);
        send(4);
        chk(second_interrupt_pin, 1'b1);
        status_is(8'h52);
        host.rd(`ISF_ADDR_READ_PORT, v);
        chk(v, sb(1, 0));
        repeat (2) @(negedge clock);
        chk(second_interrupt_pin, 1'b0);
        // Size change flushes; reserved bit reads back as 0
        host.wr(`ISF_ADDR_CONFIG, 8'h95);
        host.wr(`ISF_ADDR_CONFIG, 8'hD1);
        host.rd(`ISF_ADDR_CONFIG, v);
        chk(v, 8'h91);
        for (int k = 0; k < 17; k++) send(k);
        status_is(8'h78);
        status_is(8'h58);
        for (int k = 0; k < 16; k++) read_frame(k);
        status_is(8'h00);
        send(20);
        status_is(8'h10);
        // Streaming: oldest frame displaced
        host.wr(`ISF_ADDR_CONFIG, 8'h92);
        for (int k = 0; k < 17; k++) send(k);
        status_is(8'h78);
        read_frame(1);
        // Two sensors, largest size, three-quarter watermark
        mag_en = 1'b0;
        host.wr(`ISF_ADDR_CONFIG, 8'hBE);
        for (int k = 0; k < 96; k++) send(k);
        chk(second_interrupt_pin, 1'b1);
        status_is(8'h56);
        read_frame(0, 12);
        chk(second_interrupt_pin, 1'b0);
        // One sensor, half watermark
        gyro_en = 1'b0;
        host.wr(`ISF_ADDR_CONFIG, 8'hA9);
        for (int k = 0; k < 32; k++) send(k);
        chk(second_interrupt_pin, 1'b1);
        status_is(8'h54);
        read_frame(0, 6);
        // Bypass and unused mode keep the queue empty
        host.wr(`ISF_ADDR_CONFIG, 8'h80);
        send(5);
        chk(out_accel, accel_data);
        chk(out_gyro, gyro_data);
        chk(out_mag, mag_data);
        status_is(8'h00);
        host.wr(`ISF_ADDR_CONFIG, 8'h83);
        send(6);
        chk(out_accel, accel_data);
        status_is(8'h00);
        final_report;
    end
endmodule
